//--- src/mbd_pkg.sv
// shared constants and carriers for the memory adapter error and diagnostic block
package mbd_pkg;
   localparam int          DATA_W          = 36;
   localparam int          ADDR_W          = 22;
   localparam logic [4:0]  CTRL_ADDR       = 5'h04;
   localparam logic [4:0]  FCN_ZERO        = 5'h00;
   localparam logic [4:0]  FCN_ONE         = 5'h01;
   // data bit positions (bit 0 is the leftmost data line, held in bit 0)
   localparam int          ADR_LO          = 0;
   localparam int          FCN_LO          = 31;
   localparam int          CLEAR_BIT       = 5;
   localparam int          MODE_BIT_TWO    = 6;
   localparam int          MODE_BIT_ONE    = 7;
   localparam int          LOAD_EN_BIT     = 12;
   localparam int          LOOP_BIT        = 8;
   // function 0 return fields
   localparam int          ERR_FLD_LO      = 5;
   localparam int          RPT_MODE_LO     = 6;
   localparam int          RQ_FLD_LO       = 12;
   localparam int          READ_REQUEST_FLAG_BIT       = 11;
   localparam int          WRITE_REQUEST_FLAG_BIT       = 10;
   localparam int          ADDR_FLD_LO     = 14;
   // function 1 return fields
   localparam int          MOD_CNT_LO      = 5;
   localparam int          MEM_TYPE_LO     = 13;
   localparam int          LOOP_RET_BIT    = 17;
   // memory type code: arbitrary neutral value
   localparam logic [3:0]  MEM_TYPE_CODE   = 4'h9;
   // diagnostic cycle: four phase A periods, strobe on third, far end samples fourth
   localparam logic [2:0]  DIAG_PERIODS    = 3'h4;
   localparam logic [2:0]  STROBE_PERIOD   = 3'h3;
   // missing module timeout
   localparam real         NXM_TIMEOUT_NS  = 1000.0;
   localparam real         CLK_PERIOD_NS   = 8.0;
   localparam int          NXM_CYCLES      = int'(NXM_TIMEOUT_NS / CLK_PERIOD_NS);
   localparam logic [1:0]  MODE_RESET      = 2'h0;

   typedef struct packed {
      logic              read_request_flag;
      logic              write_request_flag;
      logic [3:0]        rq;
      logic [ADDR_W-1:0] addr;
   } mbd_req_t;

   typedef struct packed {
      logic missing_module_flag;
      logic status_write_parity_flag;
      logic status_read_parity_flag;
      logic status_addr_parity_flag;
   } mbd_status_t;
endpackage : mbd_pkg

//--- src/mbd_parity.sv
// odd parity checker on a vector with its parity bit
`timescale 1ns/1ps
`default_nettype none
module mbd_parity #(
   parameter int W = 27
) (
   // checked vector, parity included
   input  wire logic [W-1:0] vec,
   // high when parity is even, i.e. failed
   output logic              fail
);
   assign fail = ~(^vec);
endmodule : mbd_parity
`default_nettype wire

//--- src/mbd_timer.sv
// missing module timeout counter
`timescale 1ns/1ps
`default_nettype none
module mbd_timer
   import mbd_pkg::*;
#(
   parameter int LEN = NXM_CYCLES
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // control
   input  wire logic start,
   input  wire logic stop,
   // pulse when timeout passes
   output logic      expired
);
   logic [15:0] cnt_reg;
   logic        run_reg;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 16'h0000;
         run_reg <= 1'b0;
      end else if (stop) begin
         run_reg <= 1'b0;
      end else if (start) begin
         cnt_reg <= 16'h0000;
         run_reg <= 1'b1;
      end else if (run_reg) begin
         if (cnt_reg == 16'(LEN - 1)) begin
            run_reg <= 1'b0;
         end
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   assign expired = run_reg && (cnt_reg == 16'(LEN - 1)) && !stop;
endmodule : mbd_timer
`default_nettype wire

//--- src/mbd_diag.sv
// error detection and diagnostic cycle logic of the memory bus adapter
`timescale 1ns/1ps
`default_nettype none
module mbd_diag
   import mbd_pkg::*;
#(
   parameter int NXM_LEN = NXM_CYCLES
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst_b,
   // phase A indicator, one cycle pulse per phase A clock
   input  wire logic              phase_a,
   // request from the processor memory box
   input  wire logic              req_valid,
   input  wire mbd_req_t          req,
   input  wire logic              addr_parity,
   // data parity results from the data path
   input  wire logic              data_check_valid,
   input  wire logic              data_is_write,
   input  wire logic              data_parity_check,
   // memory side acknowledges and end of request
   input  wire logic              first_word_ack,
   input  wire logic              module_ack,
   input  wire logic              req_done,
   // write and read data for the loop-around buffer
   input  wire logic              wr_strobe,
   input  wire logic              rd_end,
   input  wire logic [DATA_W-1:0] bus_wdata,
   // diagnostic cycle select and data lines
   input  wire logic              diagnostic_cycle_select,
   input  wire logic [DATA_W-1:0] diag_din,
   output logic      [DATA_W-1:0] diag_dout,
   output logic                   diag_dout_en,
   // error lines to the processor
   output logic                   bus_addr_parity_error,
   output logic                   bus_error_line,
   // mode and loop state
   output logic                   mode_ff_one,
   output logic                   mode_ff_two,
   output logic                   one_bus_mode,
   output logic                   two_bus_mode,
   output logic                   four_bus_mode,
   output logic                   loop_active,
   output logic                   memory_request_enable,
   output logic      [DATA_W-1:0] loop_rdata,
   output mbd_status_t            status
);
   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0001,
      ST_SET    = 4'b0010,
      ST_STROBE = 4'b0100,
      ST_RETURN = 4'b1000
   } mbd_state_t;

   function automatic logic [4:0] field5(input logic [DATA_W-1:0] d, input int lo);
      logic [4:0] f;
      f = 5'h00;
      for (int i = 0; i < 5; i++) begin
         f[4-i] = d[lo+i];
      end
      return f;
   endfunction : field5

   logic             rst_s1_reg;
   logic             rst_s_reg;
   logic             rstn;
   mbd_state_t       state_reg;
   logic [2:0]       period_reg;
   logic             selected_reg;
   logic [4:0]       fcn_reg;
   logic             error_transmit_enable;
   logic             addr_parity_fail;
   logic             read_data_error;
   logic             write_data_error;
   logic             read_parity_error_ff;
   logic             write_parity_error_ff;
   logic             missing_module_error;
   logic             any_error;
   logic             error_address_capture_clock;
   logic             send_error;
   logic             clear_pulse;
   mbd_req_t         capture_reg;
   logic [DATA_W-1:0] buffer_reg;
   logic             strobe_now;
   logic             set_half;
   logic             hit;

   // reset release through two flip-flops
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_reg <= 1'b0;
         rst_s_reg  <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s_reg  <= rst_s1_reg;
      end
   end
   assign rstn = rst_s_reg;

   mbd_parity #(.W(ADDR_W + 5)) u_addr_par (
      .vec  ({req.addr, req.rq, addr_parity}),
      .fail (addr_parity_fail)
   );

   mbd_timer #(.LEN(NXM_LEN)) u_nxm (
      .ref_clk (ref_clk),
      .rst_b   (rstn),
      .start   (first_word_ack),
      .stop    (module_ack || req_done),
      .expired (missing_module_error)
   );

   assign read_data_error  = data_check_valid && !data_is_write && !data_parity_check;
   assign write_data_error = data_check_valid && data_is_write && !data_parity_check;

   // diagnostic cycle sequencing, counted in phase A periods
   assign hit        = field5(diag_din, ADR_LO) == CTRL_ADDR;
   // first half of the cycle, while the far end still drives conditions
   assign set_half   = (state_reg == ST_SET) || (state_reg == ST_STROBE);
   assign strobe_now = set_half && phase_a && (period_reg == STROBE_PERIOD - 3'h1);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= ST_IDLE;
         period_reg   <= 3'h0;
         selected_reg <= 1'b0;
         fcn_reg      <= 5'h00;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (diagnostic_cycle_select && phase_a) begin
                  state_reg  <= ST_SET;
                  period_reg <= 3'h1;
               end
            end
            ST_SET: begin
               if (phase_a) begin
                  period_reg <= period_reg + 3'h1;
                  state_reg  <= ST_STROBE;
               end
            end
            ST_STROBE: begin
               // third phase A pulse: the data lines are taken here
               if (strobe_now) begin
                  selected_reg <= hit;
                  fcn_reg      <= field5(diag_din, FCN_LO);
                  period_reg   <= DIAG_PERIODS;
                  state_reg    <= ST_RETURN;
               end
            end
            ST_RETURN: begin
               // far end samples on the fourth phase A, then the cycle ends
               if (phase_a) begin
                  selected_reg <= 1'b0;
                  period_reg   <= 3'h0;
                  state_reg    <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   logic set_f0;
   logic set_f1;
   assign set_f0 = strobe_now && hit && field5(diag_din, FCN_LO) == FCN_ZERO;
   assign set_f1 = strobe_now && hit && field5(diag_din, FCN_LO) == FCN_ONE;
   assign clear_pulse = set_f0 && diag_din[CLEAR_BIT];
   assign error_transmit_enable = (state_reg == ST_RETURN) && selected_reg;

   // error flip-flops; a new error wins over a clear in the same cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         read_parity_error_ff <= 1'b0;
      end else if (read_data_error) begin
         read_parity_error_ff <= 1'b1;
      end else if (clear_pulse) begin
         read_parity_error_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         write_parity_error_ff <= 1'b0;
      end else if (write_data_error) begin
         write_parity_error_ff <= 1'b1;
      end else if (clear_pulse) begin
         write_parity_error_ff <= 1'b0;
      end
   end

   // status flags share the same clear term; the read and write flags also share the set terms
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status <= '0;
      end else begin
         if (addr_parity_fail && req_valid) begin
            status.status_addr_parity_flag <= 1'b1;
         end else if (clear_pulse) begin
            status.status_addr_parity_flag <= 1'b0;
         end
         if (read_data_error) begin
            status.status_read_parity_flag <= 1'b1;
         end else if (clear_pulse) begin
            status.status_read_parity_flag <= 1'b0;
         end
         if (write_data_error) begin
            status.status_write_parity_flag <= 1'b1;
         end else if (clear_pulse) begin
            status.status_write_parity_flag <= 1'b0;
         end
         if (missing_module_error) begin
            status.missing_module_flag <= 1'b1;
         end else if (clear_pulse) begin
            status.missing_module_flag <= 1'b0;
         end
      end
   end

   assign any_error = read_parity_error_ff || write_parity_error_ff
                      || status.missing_module_flag || status.status_addr_parity_flag;
   assign send_error = read_parity_error_ff || write_parity_error_ff || status.missing_module_flag;
   assign error_address_capture_clock = req_valid && !any_error;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         bus_addr_parity_error <= 1'b0;
         bus_error_line        <= 1'b0;
      end else begin
         bus_addr_parity_error <= req_valid && addr_parity_fail;
         // a new read, write or missing module error shows on the line in the same cycle as its flag
         bus_error_line        <= send_error || read_data_error || write_data_error
                                  || missing_module_error;
      end
   end

   // error address capture; the failing request stays once any error is held
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         capture_reg <= '0;
      end else if (error_address_capture_clock) begin
         capture_reg <= req;
      end
   end

   // bus mode flip-flops
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         mode_ff_one <= 1'b0;
         mode_ff_two <= 1'b0;
      end else if (set_f0 && diag_din[LOAD_EN_BIT]) begin
         mode_ff_one <= diag_din[MODE_BIT_ONE];
         mode_ff_two <= diag_din[MODE_BIT_TWO];
      end
   end
   assign one_bus_mode  = mode_ff_one && !mode_ff_two;
   assign two_bus_mode  = !mode_ff_one && mode_ff_two;
   assign four_bus_mode = mode_ff_one && mode_ff_two;

   // loop-around; a function 1 cycle sets or clears it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         loop_active <= 1'b0;
      end else if (set_f1) begin
         loop_active <= diag_din[LOOP_BIT] && four_bus_mode;
      end else if (loop_active && rd_end) begin
         loop_active <= 1'b0;
      end
   end

   // no memory requests while looping around
   assign memory_request_enable = !loop_active && (mode_ff_one || mode_ff_two);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         buffer_reg <= '0;
      end else if (wr_strobe) begin
         buffer_reg <= bus_wdata;
      end
   end
   assign loop_rdata = buffer_reg;

   // return data, built from state already updated in the first half
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         diag_dout    <= '0;
         diag_dout_en <= 1'b0;
      end else begin
         diag_dout    <= '0;
         diag_dout_en <= 1'b0;
         if (error_transmit_enable) begin
            diag_dout_en <= 1'b1;
            for (int i = 0; i < 5; i++) begin
               diag_dout[FCN_LO+i] <= fcn_reg[4-i];
            end
            if (fcn_reg == FCN_ZERO) begin
               diag_dout[ERR_FLD_LO]            <= status.status_addr_parity_flag;
               diag_dout[ERR_FLD_LO+3]          <= status.status_read_parity_flag;
               diag_dout[ERR_FLD_LO+4]          <= status.status_write_parity_flag;
               diag_dout[ERR_FLD_LO+5]          <= status.missing_module_flag;
               diag_dout[MODE_BIT_ONE]          <= mode_ff_one;
               diag_dout[MODE_BIT_TWO]          <= mode_ff_two;
               diag_dout[READ_REQUEST_FLAG_BIT]             <= capture_reg.read_request_flag;
               diag_dout[WRITE_REQUEST_FLAG_BIT]             <= capture_reg.write_request_flag;
               diag_dout[RQ_FLD_LO +: 4]        <= capture_reg.rq;
               diag_dout[ADDR_FLD_LO +: ADDR_W] <= capture_reg.addr;
            end else if (fcn_reg == FCN_ONE) begin
               diag_dout[MOD_CNT_LO +: 8]   <= 8'h00;
               diag_dout[MEM_TYPE_LO +: 4]  <= MEM_TYPE_CODE;
               diag_dout[LOOP_RET_BIT]      <= loop_active;
            end
         end
      end
   end
endmodule : mbd_diag
`default_nettype wire

//--- testbench/mbd_diag_monitor.sv
// assertion checker for the adapter error and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module mbd_diag_monitor
   import mbd_pkg::*;
#(
   parameter int NXM_LEN = 8
) (
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rst_b,
   // causes
   input wire logic              req_valid,
   input wire mbd_req_t          req,
   input wire logic              addr_parity,
   input wire logic              data_check_valid,
   input wire logic              data_is_write,
   input wire logic              data_parity_check,
   input wire logic              rd_end,
   input wire logic [DATA_W-1:0] diag_din,
   // results
   input wire logic              diag_dout_en,
   input wire logic              bus_addr_parity_error,
   input wire logic              bus_error_line,
   input wire logic              mode_ff_one,
   input wire logic              mode_ff_two,
   input wire logic              one_bus_mode,
   input wire logic              four_bus_mode,
   input wire logic              loop_active,
   input wire logic              memory_request_enable,
   input wire mbd_status_t       status
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   wire logic bad_adr = req_valid && !(^{req.addr, addr_parity, req.rq});
   wire logic bad_dat = data_check_valid && !data_parity_check;
   AST_ADDR_PAR: assert property (bad_adr |=>
      bus_addr_parity_error && status.status_addr_parity_flag) else $error("address parity not flagged");
   AST_WR_ERR: assert property (bad_dat && data_is_write |=>
      status.status_write_parity_flag && bus_error_line) else $error("write parity not flagged");
   AST_RD_ERR: assert property (bad_dat && !data_is_write |=>
      status.status_read_parity_flag && bus_error_line) else $error("read parity not flagged");
   AST_MODE_DEC: assert property ((four_bus_mode == (mode_ff_one && mode_ff_two)) &&
      (one_bus_mode == (mode_ff_one && !mode_ff_two))) else $error("bus mode decode wrong");
   AST_MEM_EN: assert property (memory_request_enable ==
      (!loop_active && (mode_ff_one || mode_ff_two))) else $error("memory request enable wrong");
   AST_LOOP_4BUS: assert property ($rose(loop_active) |-> $past(four_bus_mode))
      else $error("loop entered outside 4 bus mode");
   AST_LOOP_CLR: assert property (loop_active && rd_end |=> !loop_active)
      else $error("loop not cleared at read end");
   AST_DIAG_ADR: assert property ($rose(diag_dout_en) |->
      $past({diag_din[0], diag_din[1], diag_din[2], diag_din[3], diag_din[4]}, 2) == CTRL_ADDR)
      else $error("answered a foreign controller address");
   AST_NXM_LINE: assert property ($rose(status.missing_module_flag) |-> bus_error_line)
      else $error("missing module without error line");
   COV_LOOP: cover property ($rose(loop_active));
   COV_NXM: cover property ($rose(status.missing_module_flag));
   COV_DIAG: cover property ($rose(diag_dout_en));
endmodule : mbd_diag_monitor
bind mbd_diag mbd_diag_monitor #(.NXM_LEN(NXM_LEN)) i_mbd_diag_monitor (
   .ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .addr_parity(addr_parity),
   .data_check_valid(data_check_valid), .data_is_write(data_is_write), .data_parity_check(data_parity_check),
   .rd_end(rd_end), .diag_din(diag_din), .diag_dout_en(diag_dout_en),
   .bus_addr_parity_error(bus_addr_parity_error), .bus_error_line(bus_error_line),
   .mode_ff_one(mode_ff_one), .mode_ff_two(mode_ff_two), .one_bus_mode(one_bus_mode),
   .four_bus_mode(four_bus_mode), .loop_active(loop_active),
   .memory_request_enable(memory_request_enable), .status(status));
`default_nettype wire

//--- testbench/mbd_processor_memory_box_model.sv
// processor memory box model: phase A marker and diagnostic cycles
`timescale 1ns/1ps
`default_nettype none
module mbd_processor_memory_box_model
   import mbd_pkg::*;
(
   // clock
   input  wire logic              ref_clk,
   // toward the adapter
   output logic                   phase_a,
   output logic                   diagnostic_cycle_select,
   output logic      [DATA_W-1:0] diag_din,
   // returned data
   input  wire logic [DATA_W-1:0] diag_dout,
   input  wire logic              diag_dout_en
);
   logic [1:0] ph_cnt_reg = 2'h0;
   always_ff @(posedge ref_clk) begin
      ph_cnt_reg <= ph_cnt_reg + 2'h1;
   end
   assign phase_a = (ph_cnt_reg == 2'h0);
   initial begin
      diagnostic_cycle_select = 1'b0;
      diag_din = '0;
   end
   // one cycle of four phase A periods, data lines only
   task automatic run(input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] r, output logic en,
                      output logic ok);
      int n;
      int k;
      n = 0;
      k = 0;
      ok = 1'b0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (ph_cnt_reg != 2'h3 && k < 8);
      diagnostic_cycle_select <= 1'b1;
      diag_din <= w;
      while (n < 4 && k < 40) begin
         @(posedge ref_clk);
         k++;
         if (phase_a) begin
            n++;
         end
         if (n == 3) begin
            diag_din <= ~w; // released lines must not keep the old value
         end
      end
      r = diag_dout;
      en = diag_dout_en;
      ok = (n == 4);
      diagnostic_cycle_select <= 1'b0;
   endtask : run
endmodule : mbd_processor_memory_box_model
`default_nettype wire

//--- testbench/mbd_diag_tb.sv
// self-checking bench for the adapter error and diagnostic block
`timescale 1ns/1ps
`default_nettype none
module mbd_diag_tb;
   import mbd_pkg::*;
   localparam int NL = 8; // short timeout keeps the run brief
   logic              ref_clk = 1'b0;
   logic              rst_b = 1'b0;
   logic              req_valid = 1'b0;
   mbd_req_t          req = '0;
   logic              addr_parity = 1'b0;
   logic              dcv = 1'b0;
   logic              dwr = 1'b0;
   logic              dpc = 1'b1;
   logic              fwa = 1'b0;
   logic              mack = 1'b0;
   logic              rdone = 1'b0;
   logic              wrs = 1'b0;
   logic              rde = 1'b0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] r;
   logic              en;
   wire logic         phase_a, sel, den, bape, bel, m1, m2, o1, o2, o4, lpa, mre;
   wire logic [DATA_W-1:0] din, dout, lrd;
   wire mbd_status_t  st;
   int                err_total = 0;
   int                checks = 0;
   mbd_diag #(.NXM_LEN(NL)) i_mbd_diag (
      .ref_clk(ref_clk), .rst_b(rst_b), .phase_a(phase_a), .req_valid(req_valid), .req(req),
      .addr_parity(addr_parity), .data_check_valid(dcv), .data_is_write(dwr), .data_parity_check(dpc),
      .first_word_ack(fwa), .module_ack(mack), .req_done(rdone), .wr_strobe(wrs), .rd_end(rde),
      .bus_wdata(wdata), .diagnostic_cycle_select(sel), .diag_din(din), .diag_dout(dout),
      .diag_dout_en(den), .bus_addr_parity_error(bape), .bus_error_line(bel), .mode_ff_one(m1),
      .mode_ff_two(m2), .one_bus_mode(o1), .two_bus_mode(o2), .four_bus_mode(o4), .loop_active(lpa),
      .memory_request_enable(mre), .loop_rdata(lrd), .status(st));
   mbd_processor_memory_box_model i_mbd_processor_memory_box_model (.ref_clk(ref_clk), .phase_a(phase_a), .diagnostic_cycle_select(sel),
      .diag_din(din), .diag_dout(dout), .diag_dout_en(den));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic finish_test;
      if (err_total == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic diag(input logic [DATA_W-1:0] w);
      logic ok;
      i_mbd_processor_memory_box_model.run(w, r, en, ok);
      if (!ok) begin
         err_total++;
         finish_test();
      end
   endtask : diag
   // function 0 word; controller address 4 with line 0 most significant
   function automatic logic [DATA_W-1:0] f0w(input logic one, input logic two, input logic ld, input logic clr);
      f0w = '0;
      f0w[2] = 1'b1;
      f0w[MODE_BIT_ONE] = one;
      f0w[MODE_BIT_TWO] = two;
      f0w[LOAD_EN_BIT] = ld;
      f0w[CLEAR_BIT] = clr;
   endfunction : f0w
   task automatic t_reset;
      @(negedge ref_clk);
      chk({m1, m2, lpa, mre, bape, bel, den, st}, 11'h000);
   endtask : t_reset
   task automatic t_modes;
      for (int k = 0; k < 4; k++) begin
         diag(f0w(k[0], k[1], 1'b1, 1'b0));
         chk({en, r[MODE_BIT_ONE], r[MODE_BIT_TWO]}, {1'b1, k[0], k[1]});
         @(negedge ref_clk);
         chk({m1, m2, o1, o2, o4, mre}, {k[0], k[1], k == 1, k == 2, k == 3, k != 0});
      end
      diag(f0w(1'b0, 1'b0, 1'b0, 1'b0));
      chk({m1, m2, r[MODE_BIT_ONE], r[MODE_BIT_TWO]}, 4'hF);
      diag(f0w(1'b0, 1'b0, 1'b1, 1'b0) ^ 36'h0_0000_0018);
      chk({en, m1, m2}, 3'h3);
      diag(36'h4_0000_0004);
      chk(r, 36'h4_0000_0000);
   endtask : t_modes
   task automatic t_errors;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req <= '{read_request_flag: 1'b1, write_request_flag: 1'b0, rq: 4'hF, addr: 22'h12_3456};
      addr_parity <= ~^{22'h12_3456, 4'hF};
      @(posedge ref_clk);
      addr_parity <= ^{22'h12_3456, 4'hF};
      @(posedge ref_clk);
      req_valid <= 1'b0;
      @(negedge ref_clk);
      chk({bape, st.status_addr_parity_flag}, 2'h3);
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req.addr <= 22'h0A_BCDE;
      addr_parity <= ~^{22'h0A_BCDE, 4'hF};
      @(negedge ref_clk);
      chk({bape, st.status_addr_parity_flag}, 2'h1);
      @(posedge ref_clk);
      req_valid <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(posedge ref_clk);
         dcv <= 1'b1;
         dwr <= k[0];
         dpc <= 1'b0;
         @(posedge ref_clk);
         dcv <= 1'b0;
         dpc <= 1'b1;
         @(negedge ref_clk);
         chk({st.status_write_parity_flag, st.status_read_parity_flag, bel}, {k[0], 2'h3});
      end
      diag(f0w(1'b1, 1'b1, 1'b0, 1'b0));
      chk({en, r[35:14], r[11], r[9:8], r[5]}, {1'b1, 22'h12_3456, 4'hF});
      diag(f0w(1'b1, 1'b1, 1'b0, 1'b1));
      chk({st, m1, m2}, 6'h03);
   endtask : t_errors
   task automatic t_nxm(input logic ack);
      @(posedge ref_clk);
      fwa <= 1'b1;
      @(posedge ref_clk);
      fwa <= 1'b0;
      mack <= ack;
      @(posedge ref_clk);
      mack <= 1'b0;
      repeat (NL - 3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(st.missing_module_flag, 1'b0);
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      chk({st.missing_module_flag, bel}, {2{~ack}});
      diag(f0w(1'b1, 1'b1, 1'b0, 1'b1));
   endtask : t_nxm
   task automatic t_loop;
      diag(f0w(1'b1, 1'b0, 1'b1, 1'b0));
      diag(36'h8_0000_0104);
      @(negedge ref_clk);
      chk(lpa, 1'b0);
      diag(f0w(1'b1, 1'b1, 1'b1, 1'b0));
      diag(36'h8_0000_0104);
      chk({r[LOOP_RET_BIT], r[MEM_TYPE_LO +: 4], r[12:5]}, {1'b1, MEM_TYPE_CODE, 8'h00});
      @(negedge ref_clk);
      chk({lpa, mre}, 2'h2);
      @(posedge ref_clk);
      wrs <= 1'b1;
      wdata <= 36'h9_A5C3_0F12;
      @(posedge ref_clk);
      wrs <= 1'b0;
      rde <= 1'b1;
      @(negedge ref_clk);
      chk(lrd, 36'h9_A5C3_0F12);
      @(posedge ref_clk);
      rde <= 1'b0;
      @(negedge ref_clk);
      chk({lpa, mre}, 2'h1);
   endtask : t_loop
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_modes();
      t_errors();
      t_nxm(1'b0);
      t_nxm(1'b1);
      t_loop();
      @(posedge ref_clk);
      rst_b <= 1'b0;
      t_reset();
      finish_test();
   end
endmodule : mbd_diag_tb
`default_nettype wire
